// ---- hdl/tbl_link_ctrl.sv ----
// 10 Mb/s twisted-pair link control: transmit gating, squelch, carrier, jabber, link test, polarity
// Function
// - half duplex: collision on collision or jabber
// - full duplex: concurrent traffic is no collision
// - send Manchester while enable high and link good
// - last transition mid-cell for 1, boundary 0
// - end frame when mid transitions stop, fast
// - squelch: opposite then original within 150ns
// - data valid until 200ns without crossings
// - reduced squelch levels after good data
// - control bit selects lower squelch threshold
// - half duplex, not repeater: carrier on transmit and receive
// - full duplex/repeater: carrier from receive only
// - enable over 24ms disables transmitter
// - enable low 256ms before transmitter re-enabled
// - control bit disables jabber protection entirely
// - lost link pulses disable transmit, receive, collision
// - idle: 100ns link pulse every 16ms
// - inverted after seven pulses or three packets
// - correct polarity automatically and report it
// - auto-negotiation picks best common mode
`timescale 1ns/1ps
module tbl_link_ctrl
   import tbl_pkg::*;
#(
   parameter int unsigned JAB_CYC = JAB_CYC_DEF,
   parameter int unsigned UNJAB_CYC = UNJAB_CYC_DEF,
   parameter int unsigned LP_PERIOD_CYC = LP_PERIOD_CYC_DEF,
   parameter int unsigned LINK_LOSS_CYC = LINK_LOSS_CYC_DEF
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic mac_tx_en_i,
   input wire logic mac_txd_i,
   input wire tbl_rx_pins_t rx_pins_i,
   input wire logic full_duplex_i,
   input wire logic repeater_i,
   input wire logic jabber_dis_i,
   input wire logic low_squelch_i,
   input wire logic [3:0] an_local_i,
   input wire logic [3:0] an_partner_i,
   output tbl_tx_line_t tx_line_o,
   output tbl_sq_ctl_t sq_ctl_o,
   output logic crs_o,
   output logic col_o,
   output logic rx_valid_o,
   output logic rx_eop_o,
   output logic link_ok_o,
   output logic jabber_o,
   output logic pol_reversed_o,
   output tbl_an_mode_t an_mode_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   tbl_rx_pins_t rx_s;
   tbl_rx_pins_t rx_prev_r;
   tbl_sq_state_t sq_state_r;
   tbl_tx_state_t tx_state_r;
   logic pos_e;
   logic neg_e;
   logic mid_e;
   logic first_neg_r;
   logic last_neg_r;
   logic [2:0] win_cnt_r;
   logic [2:0] idle_cnt_r;
   logic [2:0] mid_cnt_r;
   logic lp_evt;
   logic eop_evt;
   logic [2:0] lp_inv_cnt_r;
   logic [1:0] pkt_inv_cnt_r;
   logic pol_inv_r;
   logic link_ok_r;
   logic [CNT_W-1:0] link_cnt_r;
   logic jab_r;
   logic [CNT_W-1:0] jab_cnt_r;
   logic tx_ok;
   logic tx_phase_r;
   logic tx_bit_r;
   logic [CNT_W-1:0] lp_cnt_r;
   logic [1:0] lp_w_r;
   logic tx_active;
   logic rx_valid;
   logic half;

   tbl_sync3 #(
      .W($bits(tbl_rx_pins_t))
   ) u_rx_sync (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(rx_pins_i),
      .sync_o(rx_s)
   );

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_prev_r <= '0;
      end else begin
         rx_prev_r <= rx_s;
      end
   end

   // crossing events, swapped when the pair is found reversed
   always_comb begin
      if (pol_inv_r) begin
         pos_e = rx_s.neg & ~rx_prev_r.neg;
         neg_e = rx_s.pos & ~rx_prev_r.pos;
      end else begin
         pos_e = rx_s.pos & ~rx_prev_r.pos;
         neg_e = rx_s.neg & ~rx_prev_r.neg;
      end
      mid_e = rx_s.mid ^ rx_prev_r.mid;
   end

   // a lone crossing with no opposite one in time is a link pulse
   assign lp_evt = (sq_state_r == SQ_FIRST) && (win_cnt_r == SQ_WIN_LAST) && !(first_neg_r ? pos_e : neg_e);
   assign eop_evt = (sq_state_r == SQ_VALID) && link_ok_r &&
                    ((idle_cnt_r == SQ_IDLE_LIM) || (mid_cnt_r == EOP_LIM));

   // squelch qualification
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sq_state_r <= SQ_IDLE;
         first_neg_r <= 1'b0;
         win_cnt_r <= '0;
      end else begin
         unique case (sq_state_r)
            SQ_IDLE: begin
               if (pos_e | neg_e) begin
                  sq_state_r <= SQ_FIRST;
                  first_neg_r <= neg_e & ~pos_e;
                  win_cnt_r <= '0;
               end
            end
            SQ_FIRST: begin
               if (first_neg_r ? pos_e : neg_e) begin
                  sq_state_r <= SQ_SECOND;
                  win_cnt_r <= '0;
               end else if (win_cnt_r == SQ_WIN_LAST) begin
                  sq_state_r <= SQ_IDLE;
               end else begin
                  win_cnt_r <= win_cnt_r + 3'h1;
               end
            end
            SQ_SECOND: begin
               if ((first_neg_r ? neg_e : pos_e) && link_ok_r) begin
                  sq_state_r <= SQ_VALID;
               end else if (win_cnt_r == SQ_WIN_LAST) begin
                  sq_state_r <= SQ_IDLE;
               end else begin
                  win_cnt_r <= win_cnt_r + 3'h1;
               end
            end
            SQ_VALID: begin
               if (!link_ok_r || eop_evt) begin
                  sq_state_r <= SQ_IDLE;
               end
            end
         endcase
      end
   end

   // quiet-time counters while data is valid
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idle_cnt_r <= '0;
         mid_cnt_r <= '0;
         last_neg_r <= 1'b0;
      end else begin
         if (pos_e | neg_e) begin
            last_neg_r <= neg_e & ~pos_e;
         end
         if (sq_state_r != SQ_VALID || pos_e || neg_e) begin
            idle_cnt_r <= '0;
         end else if (idle_cnt_r != SQ_IDLE_LIM) begin
            idle_cnt_r <= idle_cnt_r + 3'h1;
         end
         if (sq_state_r != SQ_VALID || mid_e) begin
            mid_cnt_r <= '0;
         end else if (mid_cnt_r != EOP_LIM) begin
            mid_cnt_r <= mid_cnt_r + 3'h1;
         end
      end
   end

   // polarity detection, counted in the corrected sense
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lp_inv_cnt_r <= '0;
         pkt_inv_cnt_r <= '0;
         pol_inv_r <= 1'b0;
      end else if ((lp_evt && first_neg_r && lp_inv_cnt_r == POL_LP_LAST) ||
                   (eop_evt && last_neg_r && pkt_inv_cnt_r == POL_PKT_LAST)) begin
         pol_inv_r <= ~pol_inv_r;
         lp_inv_cnt_r <= '0;
         pkt_inv_cnt_r <= '0;
      end else begin
         if (lp_evt) begin
            lp_inv_cnt_r <= first_neg_r ? lp_inv_cnt_r + 3'h1 : 3'h0;
         end
         if (eop_evt) begin
            pkt_inv_cnt_r <= last_neg_r ? pkt_inv_cnt_r + 2'h1 : 2'h0;
         end
      end
   end

   // link integrity
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_ok_r <= 1'b0;
         link_cnt_r <= '0;
      end else if (lp_evt || (sq_state_r == SQ_VALID)) begin
         link_cnt_r <= '0;
         if (lp_evt) begin
            link_ok_r <= 1'b1;
         end
      end else if (link_cnt_r == CNT_W'(LINK_LOSS_CYC - 1)) begin
         link_ok_r <= 1'b0;
      end else begin
         link_cnt_r <= link_cnt_r + 1'b1;
      end
   end

   // jabber: one counter for the on time and the un-jab time
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         jab_r <= 1'b0;
         jab_cnt_r <= '0;
      end else if (jabber_dis_i) begin
         jab_r <= 1'b0;
         jab_cnt_r <= '0;
      end else if (!jab_r) begin
         if (!mac_tx_en_i) begin
            jab_cnt_r <= '0;
         end else if (jab_cnt_r == CNT_W'(JAB_CYC)) begin
            jab_r <= 1'b1;
            jab_cnt_r <= '0;
         end else begin
            jab_cnt_r <= jab_cnt_r + 1'b1;
         end
      end else begin
         if (mac_tx_en_i) begin
            jab_cnt_r <= '0;
         end else if (jab_cnt_r == CNT_W'(UNJAB_CYC - 1)) begin
            jab_r <= 1'b0;
            jab_cnt_r <= '0;
         end else begin
            jab_cnt_r <= jab_cnt_r + 1'b1;
         end
      end
   end

   assign tx_ok = mac_tx_en_i & link_ok_r & ~jab_r;

   // transmit sequencer: one half bit per clock
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_state_r <= TX_IDLE;
         tx_phase_r <= 1'b0;
         tx_bit_r <= 1'b0;
         lp_w_r <= '0;
      end else begin
         unique case (tx_state_r)
            TX_IDLE: begin
               if (tx_ok) begin
                  tx_state_r <= TX_DATA;
                  tx_phase_r <= 1'b0;
                  tx_bit_r <= mac_txd_i;
               end else if (lp_cnt_r == CNT_W'(LP_PERIOD_CYC - 1)) begin
                  tx_state_r <= TX_LP;
                  lp_w_r <= '0;
               end
            end
            TX_DATA: begin
               if (!tx_phase_r) begin
                  tx_phase_r <= 1'b1;
               end else if (tx_ok) begin
                  tx_phase_r <= 1'b0;
                  tx_bit_r <= mac_txd_i;
               end else begin
                  tx_state_r <= tx_bit_r ? TX_IDLE : TX_TAIL;
               end
            end
            TX_TAIL: begin
               tx_state_r <= TX_IDLE;
            end
            TX_LP: begin
               if (lp_w_r == LP_W_LAST) begin
                  tx_state_r <= TX_IDLE;
               end else begin
                  lp_w_r <= lp_w_r + 2'h1;
               end
            end
         endcase
      end
   end

   // link pulse interval runs only while the transmitter is idle
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lp_cnt_r <= '0;
      end else if (tx_state_r != TX_IDLE || tx_ok) begin
         lp_cnt_r <= '0;
      end else begin
         lp_cnt_r <= lp_cnt_r + 1'b1;
      end
   end

   // line level: first half inverted bit, second half true bit
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_line_o <= '0;
      end else begin
         unique case (tx_state_r)
            TX_IDLE: tx_line_o <= '0;
            TX_DATA: tx_line_o <= '{drive: 1'b1, level: tx_phase_r ? tx_bit_r : ~tx_bit_r};
            TX_TAIL: tx_line_o <= '{drive: 1'b1, level: 1'b1};
            TX_LP: tx_line_o <= '{drive: 1'b1, level: 1'b1};
         endcase
      end
   end

   assign tx_active = (tx_state_r == TX_DATA) || (tx_state_r == TX_TAIL);
   assign rx_valid = (sq_state_r == SQ_VALID);
   assign half = ~full_duplex_i;

   // carrier and collision toward the MAC
   assign crs_o = link_ok_r & (rx_valid | (half & ~repeater_i & tx_active));
   assign col_o = link_ok_r & half & ((tx_active & rx_valid) | jab_r);

   // status outputs and squelch control toward the analog receiver
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sq_ctl_o <= '0;
         rx_eop_o <= 1'b0;
         an_mode_o <= AN_NONE;
      end else begin
         sq_ctl_o.low <= low_squelch_i;
         sq_ctl_o.reduced <= (sq_state_r == SQ_VALID) && !eop_evt;
         rx_eop_o <= eop_evt;
         if (an_local_i[AB_100FD] & an_partner_i[AB_100FD]) begin
            an_mode_o <= AN_100FD;
         end else if (an_local_i[AB_100HD] & an_partner_i[AB_100HD]) begin
            an_mode_o <= AN_100HD;
         end else if (an_local_i[AB_10FD] & an_partner_i[AB_10FD]) begin
            an_mode_o <= AN_10FD;
         end else if (an_local_i[AB_10HD] & an_partner_i[AB_10HD]) begin
            an_mode_o <= AN_10HD;
         end else begin
            an_mode_o <= AN_NONE;
         end
      end
   end

   assign rx_valid_o = rx_valid;
   assign link_ok_o = link_ok_r;
   assign jabber_o = jab_r;
   assign pol_reversed_o = pol_inv_r;

   a_col_half_only: assert property (col_o |-> !full_duplex_i)
      else $error("collision reported in full duplex");
   a_col_on_jabber: assert property ($rose(jab_r) && half && link_ok_r |-> col_o)
      else $error("jabber without collision");
   a_tx_stops_enable: assert property ($fell(mac_tx_en_i) |-> ##[1:3] !tx_active)
      else $error("transmit continues after enable fell");
   a_tail_after_zero: assert property (tx_state_r == TX_DATA && tx_phase_r && !tx_ok && !tx_bit_r
                                       |=> tx_state_r == TX_TAIL ##1 tx_line_o.level ##1 !tx_line_o.drive)
      else $error("last zero bit without boundary transition");
   a_valid_order: assert property ($rose(rx_valid) |-> $past(sq_state_r) == SQ_SECOND)
      else $error("data valid without full squelch sequence");
   a_first_window: assert property (sq_state_r == SQ_FIRST && !pos_e && !neg_e [*3] |=> sq_state_r == SQ_IDLE)
      else $error("opposite crossing window too long");
   a_quiet_end: assert property (rx_valid && !pos_e && !neg_e [*5] |=> !rx_valid)
      else $error("valid data held past quiet time");
   a_crs_rx_only: assert property (crs_o && (full_duplex_i || repeater_i) |-> rx_valid)
      else $error("carrier from own transmission");
   a_crs_tx_half: assert property (tx_active && link_ok_r && half && !repeater_i |-> crs_o)
      else $error("no carrier during half duplex transmit");
   a_jab_blocks_tx: assert property (jab_r && $past(jab_r, 3) |-> !tx_active)
      else $error("transmit while jabbered");
   a_lp_width: assert property ($rose(tx_state_r == TX_LP) |-> tx_state_r == TX_LP [*2] ##1 tx_state_r != TX_LP)
      else $error("link pulse width wrong");
   a_pol_flip_cause: assert property ($changed(pol_inv_r) |-> $past(lp_inv_cnt_r) == POL_LP_LAST
                                      || $past(pkt_inv_cnt_r) == POL_PKT_LAST)
      else $error("polarity changed without enough inverted events");
   a_link_gates: assert property (!link_ok_r |-> !crs_o && !col_o && !tx_active ##1 !rx_valid)
      else $error("activity without link");

   c_rx_valid: cover property ($rose(rx_valid));
   c_jabber: cover property ($rose(jab_r));
   c_pol_flip: cover property ($rose(pol_inv_r));
   c_collision: cover property (col_o && !jab_r);
endmodule // tbl_link_ctrl

// ---- inc/tbl_pkg.sv ----
// package of constants and types for the 10 Mb/s twisted-pair link control
package tbl_pkg;
   // clock
   localparam int unsigned CLK_NS = 50;
   localparam int CNT_W = 24;
   // squelch timing
   localparam int unsigned SQ_WIN_NS = 150;
   localparam int unsigned SQ_WIN_CYC = SQ_WIN_NS / CLK_NS;
   localparam int unsigned SQ_IDLE_NS = 200;
   localparam int unsigned SQ_IDLE_CYC = (SQ_IDLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned EOP_NS = 150;
   localparam int unsigned EOP_CYC = EOP_NS / CLK_NS;
   localparam logic [2:0] SQ_WIN_LAST = 3'(SQ_WIN_CYC - 1);
   localparam logic [2:0] SQ_IDLE_LIM = 3'(SQ_IDLE_CYC);
   localparam logic [2:0] EOP_LIM = 3'(EOP_CYC);
   // link pulse width
   localparam int unsigned LP_NS = 100;
   localparam int unsigned LP_CYC = (LP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] LP_W_LAST = 2'(LP_CYC - 1);
   // long timers, in microseconds
   localparam int unsigned JAB_US = 24000;
   localparam int unsigned UNJAB_US = 256000;
   localparam int unsigned LP_PERIOD_US = 16000;
   localparam int unsigned LINK_LOSS_US = 100000;
   localparam int unsigned JAB_CYC_DEF = JAB_US * 1000 / CLK_NS;
   localparam int unsigned UNJAB_CYC_DEF = UNJAB_US * 1000 / CLK_NS;
   localparam int unsigned LP_PERIOD_CYC_DEF = LP_PERIOD_US * 1000 / CLK_NS;
   localparam int unsigned LINK_LOSS_CYC_DEF = LINK_LOSS_US * 1000 / CLK_NS;
   // polarity decision counts
   localparam int unsigned POL_LP_CNT = 7;
   localparam int unsigned POL_PKT_CNT = 3;
   localparam logic [2:0] POL_LP_LAST = 3'(POL_LP_CNT - 1);
   localparam logic [1:0] POL_PKT_LAST = 2'(POL_PKT_CNT - 1);
   // ability bit positions
   localparam int AB_10HD = 0;
   localparam int AB_10FD = 1;
   localparam int AB_100HD = 2;
   localparam int AB_100FD = 3;

   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00,
      SQ_FIRST = 2'b01,
      SQ_SECOND = 2'b10,
      SQ_VALID = 2'b11
   } tbl_sq_state_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_DATA = 2'b01,
      TX_TAIL = 2'b10,
      TX_LP = 2'b11
   } tbl_tx_state_t;

   typedef enum logic [2:0] {
      AN_NONE = 3'b000,
      AN_10HD = 3'b001,
      AN_10FD = 3'b010,
      AN_100HD = 3'b011,
      AN_100FD = 3'b100
   } tbl_an_mode_t;

   typedef struct packed {
      logic pos;
      logic neg;
      logic mid;
   } tbl_rx_pins_t;

   typedef struct packed {
      logic drive;
      logic level;
   } tbl_tx_line_t;

   typedef struct packed {
      logic low;
      logic reduced;
   } tbl_sq_ctl_t;
endpackage

// ---- hdl/tbl_sync3.sv ----
// three-stage input synchroniser that passes a bit once stages two and three agree
`timescale 1ns/1ps
module tbl_sync3 #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         sync_o <= '0;
      end else begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         sync_o <= (s2_r & s3_r) | (sync_o & (s2_r ^ s3_r));
      end
   end
endmodule // tbl_sync3

// ---- dv/tbl_far_end.sv ----
// remote link partner model driving the squelch-level receive pins
`timescale 1ns/1ps
module tbl_far_end
   import tbl_pkg::*;
(
   input wire logic sys_clk_i,
   output tbl_rx_pins_t rx_pins_o
);
   initial begin
      rx_pins_o = '0;
   end

   // lone crossing of one threshold; inv uses the negative side
   task automatic send_lp(input logic inv);
      @(posedge sys_clk_i);
      rx_pins_o.pos <= !inv;
      rx_pins_o.neg <= inv;
      repeat (2) @(posedge sys_clk_i);
      rx_pins_o.pos <= 1'b0;
      rx_pins_o.neg <= 1'b0;
      repeat (12) @(posedge sys_clk_i);
   endtask

   // alternating crossings held two clocks each, mid toggling with each one;
   // the frame ends on a negative crossing when inv_end is set
   task automatic send_pkt(input int nbits, input logic inv_end);
      for (int i = 0; i < 2 * nbits + (inv_end ? 0 : 1); i++) begin
         @(posedge sys_clk_i);
         rx_pins_o.pos <= (i % 2 == 0);
         rx_pins_o.neg <= (i % 2 == 1);
         rx_pins_o.mid <= !rx_pins_o.mid;
         @(posedge sys_clk_i);
      end
      @(posedge sys_clk_i);
      // released line falls below both thresholds
      rx_pins_o.pos <= 1'b0;
      rx_pins_o.neg <= 1'b0;
   endtask
endmodule // tbl_far_end

// ---- dv/test_tbl_link_ctrl.sv ----
// self-checking testbench for the 10 Mb/s link control
`timescale 1ns/1ps
module test_tbl_link_ctrl;
   import tbl_pkg::*;
   localparam int JAB = 200;
   localparam int UNJAB = 400;
   localparam int LPP = 100;
   localparam int LOSS = 1000;
   logic clk = 1'b0;
   logic rst_n;
   logic tx_en;
   logic txd;
   logic fd;
   logic rep;
   logic jdis;
   logic lsq;
   logic [3:0] an_l;
   logic [3:0] an_p;
   tbl_rx_pins_t rx_pins;
   tbl_tx_line_t tx_line;
   tbl_sq_ctl_t sq_ctl;
   tbl_an_mode_t an_mode;
   logic crs, col, rx_valid, rx_eop, link_ok, jabber, pol_rev;
   int failures = 0;
   int checks_done = 0;

   always #25 clk = ~clk;

   tbl_far_end i_far (.sys_clk_i(clk), .rx_pins_o(rx_pins));

   tbl_link_ctrl #(.JAB_CYC(JAB), .UNJAB_CYC(UNJAB), .LP_PERIOD_CYC(LPP), .LINK_LOSS_CYC(LOSS)) i_dut (
      .sys_clk_i(clk), .reset_n_i(rst_n), .mac_tx_en_i(tx_en), .mac_txd_i(txd), .rx_pins_i(rx_pins),
      .full_duplex_i(fd), .repeater_i(rep), .jabber_dis_i(jdis), .low_squelch_i(lsq),
      .an_local_i(an_l), .an_partner_i(an_p), .tx_line_o(tx_line), .sq_ctl_o(sq_ctl), .crs_o(crs),
      .col_o(col), .rx_valid_o(rx_valid), .rx_eop_o(rx_eop), .link_ok_o(link_ok), .jabber_o(jabber),
      .pol_reversed_o(pol_rev), .an_mode_o(an_mode));

   task automatic wrap_up;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_mode(input tbl_an_mode_t e, input tbl_an_mode_t g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] an_mode expected %0d seen %0d", e, g);
      end
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: return tx_line.drive;
         1: return rx_valid;
         2: return jabber;
         3: return link_ok;
         default: return rx_eop;
      endcase
   endfunction

   // bounded wait, sampled on falling edges
   task automatic wait_on(input int w, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(w) !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (pick(w) !== v) begin
         failures++;
         $display("[ERR] wait on select %0d expected %b seen %b", w, v, pick(w));
         wrap_up();
      end
   endtask

   // start just after an outgoing link pulse so none collides with the test
   task automatic align;
      wait_on(0, 1'b1, 2 * LPP + 20);
      wait_on(0, 1'b0, 10);
   endtask

   task automatic t_lp_out;
      int n;
      int hits;
      chk_bit("link_ok", 1'b0, link_ok);
      chk_mode(AN_NONE, an_mode);
      wait_on(0, 1'b1, 2 * LPP);
      chk_bit("lp_level", 1'b1, tx_line.level);
      n = 0;
      while (tx_line.drive === 1'b1 && n < 5) begin
         @(negedge clk);
         n++;
      end
      chk_bit("lp_width", 1'b1, n == 2);
      while (tx_line.drive !== 1'b1 && n < 3 * LPP) begin
         @(negedge clk);
         n++;
      end
      chk_bit("lp_period", 1'b1, n >= LPP && n <= LPP + 4);
      wait_on(0, 1'b0, 10);
      hits = 0;
      @(posedge clk);
      tx_en <= 1'b1;
      repeat (20) begin
         @(negedge clk);
         hits += int'(tx_line.drive === 1'b1);
      end
      @(posedge clk);
      tx_en <= 1'b0;
      chk_bit("tx_refused", 1'b1, hits == 0);
      $display("test lp_out done");
   endtask

   task automatic t_cfg;
      tbl_an_mode_t em[6] = '{AN_100FD, AN_100HD, AN_10FD, AN_10HD, AN_NONE, AN_10HD};
      @(posedge clk);
      lsq <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk_bit("sq_low", 1'b1, sq_ctl.low);
      @(posedge clk);
      lsq <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         an_l <= (i == 5) ? 4'h5 : 4'hF;
         an_p <= (i == 5) ? 4'hB : 4'h8 >> i;
         @(posedge clk);
         @(negedge clk);
         chk_mode(em[i], an_mode);
      end
      chk_bit("sq_low_off", 1'b0, sq_ctl.low);
      $display("test cfg done");
   endtask

   task automatic t_tx(input logic [7:0] b, input int n, input logic f, input logic r);
      i_far.send_lp(1'b0);
      fd <= f;
      rep <= r;
      align();
      @(posedge clk);
      tx_en <= 1'b1;
      txd <= b[0];
      for (int j = 0; j <= 2 * n + 3; j++) begin
         @(posedge clk);
         if (j % 2 == 0 && j / 2 + 1 < n) txd <= b[j/2+1];
         if (j == 2 * n - 2) tx_en <= 1'b0;
         @(negedge clk);
         if (j >= 1 && j < 2 * n + 1) begin
            chk_bit("tx_drive", 1'b1, tx_line.drive);
            chk_bit("tx_level", b[(j-1)/2] ^ (j % 2 == 1), tx_line.level);
         end
         if (j < 2 * n) begin
            chk_bit("crs_tx", !(f | r), crs);
            chk_bit("col_tx", 1'b0, col);
         end
         if (j == 2 * n + 1) chk_bit("tail_drive", !b[n-1], tx_line.drive);
         if (j == 2 * n + 1 && !b[n-1]) chk_bit("tail_level", 1'b1, tx_line.level);
         if (j == 2 * n + 2) chk_bit("end_drive", 1'b0, tx_line.drive);
      end
      @(posedge clk);
      fd <= 1'b0;
      rep <= 1'b0;
      $display("test tx done");
   endtask

   task automatic t_rx;
      i_far.send_lp(1'b0);
      chk_bit("lone_valid", 1'b0, rx_valid);
      fork
         i_far.send_pkt(12, 1'b0);
         begin
            wait_on(1, 1'b1, 20);
            chk_bit("crs_rx", 1'b1, crs);
            @(negedge clk);
            chk_bit("sq_reduced", 1'b1, sq_ctl.reduced);
         end
      join
      wait_on(4, 1'b1, 12);
      @(negedge clk);
      chk_bit("eop_pulse", 1'b0, rx_eop);
      chk_bit("valid_end", 1'b0, rx_valid);
      chk_bit("crs_end", 1'b0, crs);
      $display("test rx done");
   endtask

   task automatic t_col(input logic f);
      i_far.send_lp(1'b0);
      fd <= f;
      align();
      @(posedge clk);
      tx_en <= 1'b1;
      txd <= 1'b1;
      fork
         i_far.send_pkt(12, 1'b0);
         begin
            wait_on(1, 1'b1, 30);
            chk_bit("col_rx_tx", !f, col);
            chk_bit("drive_rx_tx", 1'b1, tx_line.drive);
         end
      join
      tx_en <= 1'b0;
      fd <= 1'b0;
      repeat (20) @(posedge clk);
      $display("test col done");
   endtask

   task automatic t_jab(input logic dis);
      i_far.send_lp(1'b0);
      jdis <= dis;
      align();
      @(posedge clk);
      tx_en <= 1'b1;
      repeat (JAB - 20) @(negedge clk);
      chk_bit("jab_early", 1'b0, jabber);
      repeat (50) @(negedge clk);
      chk_bit("jab_on", !dis, jabber);
      chk_bit("jab_drive", dis, tx_line.drive);
      chk_bit("jab_col", !dis, col);
      @(posedge clk);
      tx_en <= 1'b0;
      if (!dis) begin
         i_far.send_lp(1'b0);
         repeat (UNJAB - 70) @(negedge clk);
         chk_bit("unjab_hold", 1'b1, jabber);
         wait_on(2, 1'b0, 80);
      end
      @(posedge clk);
      jdis <= 1'b0;
      $display("test jabber done");
   endtask

   task automatic t_pol;
      repeat (6) i_far.send_lp(1'b1);
      chk_bit("pol_six", 1'b0, pol_rev);
      i_far.send_lp(1'b1);
      chk_bit("pol_seven", 1'b1, pol_rev);
      for (int i = 0; i < 3; i++) begin
         chk_bit("pol_pkt", 1'b1, pol_rev);
         i_far.send_pkt(12, 1'b0);
         repeat (15) @(negedge clk);
      end
      chk_bit("pol_back", 1'b0, pol_rev);
      $display("test polarity done");
   endtask

   task automatic t_loss;
      wait_on(3, 1'b0, LOSS + 50);
      fork
         i_far.send_pkt(12, 1'b0);
         begin
            repeat (20) @(negedge clk);
            chk_bit("loss_valid", 1'b0, rx_valid);
            chk_bit("loss_crs", 1'b0, crs);
         end
      join
      $display("test link loss done");
   endtask

   initial begin
      {rst_n, tx_en, txd, fd, rep, jdis, lsq} <= 7'h00;
      {an_l, an_p} <= 8'h00;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      t_lp_out();
      t_cfg();
      t_tx(8'h0D, 4, 1'b0, 1'b0);
      t_tx(8'h06, 4, 1'b1, 1'b0);
      t_tx(8'h0B, 4, 1'b0, 1'b1);
      t_rx();
      t_col(1'b0);
      t_col(1'b1);
      t_jab(1'b0);
      t_jab(1'b1);
      t_pol();
      t_loss();
      wrap_up();
   end
endmodule // test_tbl_link_ctrl
